// ===== rtl/cief_top.sv
// can error state and interrupt flag register with apb slave
`timescale 1ns/1ps
//
// Notes on behaviour
// - bit 13 high while transmitter bus off
// - bit 12 high while transmitter error passive
// - bit 11 high while receiver error passive
// - bit 10 high while transmitter error warning
// - bit 9 high while receiver error warning
// - bit 8 high when either side warns
// - bit 7 latches invalid message event
// - bit 6 latches bus wakeup activity
// - bit 5 latches entry into error states
// - bit 3 latches fifo almost full
// - bit 2 latches receive buffer overflow
// - flags read pending request, zero after reset
// - only a zero write clears a flag
// - bits 15, 14, 4 read zero, ignore writes
//
module cief_top
    import cief_pkg::*;
#(
    parameter logic [CIEF_CNT_W-1:0] WARN_LIMIT    = CIEF_WARN_LIMIT,
    parameter logic [CIEF_CNT_W-1:0] PASSIVE_LIMIT = CIEF_PASSIVE_LIMIT,
    parameter logic [CIEF_CNT_W-1:0] BUS_OFF_LIMIT = CIEF_BUS_OFF_LIMIT
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [CIEF_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [CIEF_DATA_W-1:0] pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [CIEF_DATA_W-1:0] prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [CIEF_CNT_W-1:0]  tx_err_count,
    input  wire logic [CIEF_CNT_W-1:0]  rx_err_count,
    input  wire logic                   invalid_message_evt,
    input  wire logic                   wakeup_activity_evt,
    input  wire logic                   fifo_almost_full_evt,
    input  wire logic                   rx_buffer_overflow_evt,
    input  wire logic                   rx_buffer_evt,
    input  wire logic                   tx_buffer_evt,
    output logic                        irq
);
    import cief_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [CIEF_REG_W-1:0]  status;
        logic [CIEF_REG_W-1:0]  mask;
        logic [CIEF_DATA_W-1:0] prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   irq;
    } cief_state_t;

    cief_state_t state_reg;
    cief_state_t state_next;

    logic [CIEF_REG_W-1:0]  status_calc;
    logic [CIEF_REG_W-1:0]  flag_set;
    logic [CIEF_REG_W-1:0]  flags;
    logic [CIEF_REG_W-1:0]  flag_wdata;
    logic [CIEF_REG_W-1:0]  flags_view;
    logic [CIEF_DATA_W-1:0] rd_data;
    logic                   flag_wr;
    logic                   tx_off;
    logic                   access;
    logic                   wr_fire;
    logic                   hit_flags;
    logic                   hit_mask;
    logic                   hit_counts;
    logic                   addr_hit;

    ////////////////////////////////////////////////////////////////////////////
    // error state decode from the counters

    // bus off overrides the lesser transmitter states
    always_comb begin
        status_calc = '0;
        tx_off = tx_err_count >= BUS_OFF_LIMIT;
        status_calc[CIEF_BIT_TX_BUS_OFF] = tx_off;
        status_calc[CIEF_BIT_TX_PASSIVE] = !tx_off && (tx_err_count >= PASSIVE_LIMIT);
        status_calc[CIEF_BIT_RX_PASSIVE] = rx_err_count >= PASSIVE_LIMIT;
        status_calc[CIEF_BIT_TX_WARNING] = !tx_off && (tx_err_count >= WARN_LIMIT);
        status_calc[CIEF_BIT_RX_WARNING] = rx_err_count >= WARN_LIMIT;
        status_calc[CIEF_BIT_ANY_WARNING] = status_calc[CIEF_BIT_TX_WARNING]
                                          | status_calc[CIEF_BIT_RX_WARNING];
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag set sources

    // error summary fires on entry into any error state
    always_comb begin
        flag_set = '0;
        flag_set[CIEF_BIT_INVALID]     = invalid_message_evt;
        flag_set[CIEF_BIT_WAKEUP]      = wakeup_activity_evt;
        flag_set[CIEF_BIT_ERROR_SUM]   = |(status_calc & ~state_reg.status);
        flag_set[CIEF_BIT_FIFO_FULL]   = fifo_almost_full_evt;
        flag_set[CIEF_BIT_RX_OVERFLOW] = rx_buffer_overflow_evt;
        flag_set[CIEF_BIT_RX_BUFFER]   = rx_buffer_evt;
        flag_set[CIEF_BIT_TX_BUFFER]   = tx_buffer_evt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    // writes act only on the edge that completes the access
    assign access     = psel & penable;
    assign wr_fire    = access & pwrite & state_reg.pready;
    assign hit_flags  = paddr == CIEF_OFS_FLAGS;
    assign hit_mask   = paddr == CIEF_OFS_MASK;
    assign hit_counts = paddr == CIEF_OFS_COUNTS;
    assign addr_hit   = hit_flags | hit_mask | hit_counts;

    // only the low byte holds clearable flags; upper byte is status
    assign flag_wr    = wr_fire & hit_flags & pstrb[0];
    assign flag_wdata = {8'hff, pwdata[7:0]};

    // flags and live status merged; reserved bits are never driven
    assign flags_view = (flags & CIEF_FLAG_IMPL) | (state_reg.status & CIEF_STATUS_IMPL);

    ////////////////////////////////////////////////////////////////////////////
    // sticky flag bank

    cief_flag_bank #(
        .IMPL    (CIEF_FLAG_IMPL)
    ) i_cief_flag_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .set_evt (flag_set),
        .wr_en   (flag_wr),
        .wr_data (flag_wdata),
        .flags   (flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    // unmapped offsets read zero
    always_comb begin
        rd_data = '0;
        if (hit_flags) begin
            rd_data = {16'h0000, flags_view};
        end else if (hit_mask) begin
            rd_data = {16'h0000, state_reg.mask};
        end else if (hit_counts) begin
            rd_data = {7'h00, rx_err_count, 7'h00, tx_err_count};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // one wait state: pready rises in the second access cycle
    always_comb begin
        state_next         = state_reg;
        state_next.status  = status_calc;
        state_next.pready  = access & ~state_reg.pready;
        state_next.prdata  = '0;
        state_next.pslverr = 1'b0;
        if (access && !state_reg.pready) begin
            state_next.pslverr = ~addr_hit;
            if (!pwrite) begin
                state_next.prdata = rd_data;
            end
        end
        if (wr_fire && hit_mask) begin
            if (pstrb[0]) begin
                state_next.mask[7:0] = pwdata[7:0] & CIEF_FLAG_IMPL[7:0];
            end
            if (pstrb[1]) begin
                state_next.mask[15:8] = pwdata[15:8] & CIEF_FLAG_IMPL[15:8];
            end
        end
        state_next.irq = |(flags & state_reg.mask);
    end

    // state register, asynchronous reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '{status: '0, mask: CIEF_MASK_RESET, prdata: '0,
                           pready: 1'b0, pslverr: 1'b0, irq: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign prdata  = state_reg.prdata;
    assign pready  = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign irq     = state_reg.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    // bus off bit follows the transmit counter one edge later
    bus_off_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> state_reg.status[CIEF_BIT_TX_BUS_OFF] == ($past(tx_err_count) >= BUS_OFF_LIMIT))
        else $error("bus off status wrong");

    // transmit passive only between passive limit and bus off
    tx_passive_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_err_count >= PASSIVE_LIMIT && tx_err_count < BUS_OFF_LIMIT)
        |=> state_reg.status[CIEF_BIT_TX_PASSIVE] && !state_reg.status[CIEF_BIT_TX_BUS_OFF])
        else $error("tx passive status wrong");

    // receive passive tracks the receive counter
    rx_passive_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_err_count < PASSIVE_LIMIT) |=> !state_reg.status[CIEF_BIT_RX_PASSIVE])
        else $error("rx passive set below limit");

    // transmit warning cleared below the warning limit
    tx_warn_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_err_count < WARN_LIMIT) |=> !state_reg.status[CIEF_BIT_TX_WARNING])
        else $error("tx warning set below limit");

    // receive warning set at the warning limit
    rx_warn_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rx_err_count >= WARN_LIMIT) |=> state_reg.status[CIEF_BIT_RX_WARNING])
        else $error("rx warning not set");

    // combined warning is the or of both warnings
    any_warn_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_reg.status[CIEF_BIT_ANY_WARNING]
        == (state_reg.status[CIEF_BIT_TX_WARNING] | state_reg.status[CIEF_BIT_RX_WARNING]))
        else $error("combined warning mismatch");

    // invalid message event is always latched
    invalid_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        invalid_message_evt |=> flags[CIEF_BIT_INVALID])
        else $error("invalid message flag lost");

    // wakeup event is latched even during a clearing write
    wakeup_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wakeup_activity_evt && flag_wr) |=> flags[CIEF_BIT_WAKEUP])
        else $error("wakeup flag lost on clear");

    // entering bus off raises the error summary flag
    error_sum_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_reg.status[CIEF_BIT_TX_BUS_OFF]) |-> flags[CIEF_BIT_ERROR_SUM])
        else $error("error summary not raised");

    // fifo and overflow events latched
    fifo_ovf_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (fifo_almost_full_evt || rx_buffer_overflow_evt)
        |=> (flags[CIEF_BIT_FIFO_FULL] || !$past(fifo_almost_full_evt))
            && (flags[CIEF_BIT_RX_OVERFLOW] || !$past(rx_buffer_overflow_evt)))
        else $error("fifo or overflow flag lost");

    // a flag falls only after a zero write to it
    flag_fall_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(flags[CIEF_BIT_TX_BUFFER]) |-> $past(flag_wr && !pwdata[CIEF_BIT_TX_BUFFER]))
        else $error("flag cleared without zero write");

    // zero write with no new event clears the receive flag
    zero_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flag_wr && !pwdata[CIEF_BIT_RX_BUFFER] && !rx_buffer_evt) |=> !flags[CIEF_BIT_RX_BUFFER])
        else $error("zero write did not clear");

    // reserved bits of the flag register read zero
    reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access && !state_reg.pready && !pwrite && hit_flags)
        |=> (state_reg.prdata[15:14] == 2'b00) && !state_reg.prdata[4])
        else $error("reserved bits not zero");

    // transmit done event latched
    tx_done_flag_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        tx_buffer_evt |=> flags[CIEF_BIT_TX_BUFFER])
        else $error("tx buffer flag lost");

    // writes cannot disturb the error state bits
    status_ro_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flag_wr && $stable(tx_err_count) && $stable(rx_err_count))
        |=> $stable(state_reg.status))
        else $error("status moved on write");

    // the answer comes exactly one cycle into the access
    apb_wait_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |=> pready)
        else $error("apb answer late");

    // entering receive passive raises the error summary flag
    rx_passive_sum_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_reg.status[CIEF_BIT_RX_PASSIVE]) |-> flags[CIEF_BIT_ERROR_SUM])
        else $error("error summary missed rx passive");

    // writing a one keeps a pending flag
    one_write_keeps_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (flag_wr && pwdata[CIEF_BIT_INVALID] && flags[CIEF_BIT_INVALID]) |=> flags[CIEF_BIT_INVALID])
        else $error("one write cleared a flag");

    // a zero write without the low lane strobe clears nothing
    strobe_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit_flags && !pstrb[0] && flags[CIEF_BIT_RX_BUFFER]) |=> flags[CIEF_BIT_RX_BUFFER])
        else $error("unstrobed write cleared a flag");

    // unmapped offsets answer with an error and zero data
    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access && !state_reg.pready && !addr_hit) |=> pslverr && pready && (prdata == '0))
        else $error("unmapped access not refused");

    // read data and error stand only with ready
    rdata_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pready |-> (prdata == '0) && !pslverr)
        else $error("read data outside ready");

    // interrupt follows masked flags one edge later
    irq_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> irq == |($past(flags) & $past(state_reg.mask)))
        else $error("irq level wrong");

endmodule

// ===== common/cief_pkg.sv
// constants for the can error state and interrupt flag register block
package cief_pkg;

    // bus and register widths
    localparam int unsigned CIEF_ADDR_W = 8;
    localparam int unsigned CIEF_DATA_W = 32;
    localparam int unsigned CIEF_REG_W  = 16;
    localparam int unsigned CIEF_CNT_W  = 9;

    // register byte offsets
    localparam logic [CIEF_ADDR_W-1:0] CIEF_OFS_FLAGS  = 8'h00;
    localparam logic [CIEF_ADDR_W-1:0] CIEF_OFS_MASK   = 8'h04;
    localparam logic [CIEF_ADDR_W-1:0] CIEF_OFS_COUNTS = 8'h08;

    // field positions in can_interrupt_flags
    localparam int unsigned CIEF_BIT_TX_BUS_OFF  = 13;
    localparam int unsigned CIEF_BIT_TX_PASSIVE  = 12;
    localparam int unsigned CIEF_BIT_RX_PASSIVE  = 11;
    localparam int unsigned CIEF_BIT_TX_WARNING  = 10;
    localparam int unsigned CIEF_BIT_RX_WARNING  = 9;
    localparam int unsigned CIEF_BIT_ANY_WARNING = 8;
    localparam int unsigned CIEF_BIT_INVALID     = 7;
    localparam int unsigned CIEF_BIT_WAKEUP      = 6;
    localparam int unsigned CIEF_BIT_ERROR_SUM   = 5;
    localparam int unsigned CIEF_BIT_FIFO_FULL   = 3;
    localparam int unsigned CIEF_BIT_RX_OVERFLOW = 2;
    localparam int unsigned CIEF_BIT_RX_BUFFER   = 1;
    localparam int unsigned CIEF_BIT_TX_BUFFER   = 0;

    // which bits are clearable flags, which are live status
    localparam logic [CIEF_REG_W-1:0] CIEF_FLAG_IMPL   = 16'h00ef;
    localparam logic [CIEF_REG_W-1:0] CIEF_STATUS_IMPL = 16'h3f00;

    // reset values
    localparam logic [CIEF_REG_W-1:0] CIEF_FLAGS_RESET = 16'h0000;
    localparam logic [CIEF_REG_W-1:0] CIEF_MASK_RESET  = 16'h0000;

    // error counter thresholds
    localparam logic [CIEF_CNT_W-1:0] CIEF_WARN_LIMIT    = 9'h060;
    localparam logic [CIEF_CNT_W-1:0] CIEF_PASSIVE_LIMIT = 9'h080;
    localparam logic [CIEF_CNT_W-1:0] CIEF_BUS_OFF_LIMIT = 9'h100;

endpackage

// ===== rtl/cief_flag_bank.sv
// bank of sticky interrupt flags cleared by writing zero
`timescale 1ns/1ps
module cief_flag_bank
    import cief_pkg::*;
#(
    parameter logic [CIEF_REG_W-1:0] IMPL = CIEF_FLAG_IMPL
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [CIEF_REG_W-1:0] set_evt,
    input  wire logic                  wr_en,
    input  wire logic [CIEF_REG_W-1:0] wr_data,
    output logic      [CIEF_REG_W-1:0] flags
);
    import cief_pkg::*;

    typedef struct packed {
        logic [CIEF_REG_W-1:0] flags;
    } cief_bank_t;

    cief_bank_t bank_reg;
    cief_bank_t bank_next;

    // per bit: set wins over a zero write, unimplemented bits stay zero
    always_comb begin
        bank_next = bank_reg;
        for (int i = 0; i < CIEF_REG_W; i++) begin
            bank_next.flags[i] = IMPL[i] & (set_evt[i] | (bank_reg.flags[i] & ~(wr_en & ~wr_data[i])));
        end
    end

    // register the bank, all flags clear at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_reg <= '{flags: CIEF_FLAGS_RESET};
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign flags = bank_reg.flags;

endmodule

// ===== test/cief_bus_node.sv
// behavioural can bus node driving the error counters and event strobes
`timescale 1ns/1ps
module cief_bus_node
    import cief_pkg::*;
(
    input  wire logic                  pclk,
    output logic      [CIEF_CNT_W-1:0] tx_err_count,
    output logic      [CIEF_CNT_W-1:0] rx_err_count,
    output logic      [5:0]            evt
);
    // quiet bus with error-free counters until told otherwise
    initial begin
        tx_err_count = '0;
        rx_err_count = '0;
        evt = '0;
    end

    // single-cycle strobe on one event line, launched after an edge
    task automatic pulse(input int idx);
        @(posedge pclk);
        evt[idx] <= 1'b1;
        @(posedge pclk);
        evt[idx] <= 1'b0;
    endtask

    // counters move just after an edge, like the protocol engine would
    task automatic counts(input logic [CIEF_CNT_W-1:0] tx, input logic [CIEF_CNT_W-1:0] rx);
        @(posedge pclk);
        tx_err_count <= tx;
        rx_err_count <= rx;
    endtask
endmodule

// ===== test/can_error_interrupt_flags_test.sv
// self-checking bench for the can error state and interrupt flag block
`timescale 1ns/1ps
module can_error_interrupt_flags_test;
    import cief_pkg::*;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [CIEF_ADDR_W-1:0] paddr;
    logic [CIEF_DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0]            pstrb;
    logic [CIEF_CNT_W-1:0] tx_err_count, rx_err_count;
    logic [5:0]            evt;
    int                    mismatches = 0;
    int                    checks_done = 0;
    int                    flag_bit [6] = '{0, 1, 2, 3, 6, 7};

    cief_top i_cief_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
        .invalid_message_evt(evt[5]), .wakeup_activity_evt(evt[4]), .fifo_almost_full_evt(evt[3]),
        .rx_buffer_overflow_evt(evt[2]), .rx_buffer_evt(evt[1]), .tx_buffer_evt(evt[0]), .irq(irq));
    cief_bus_node i_cief_bus_node (.pclk(pclk), .tx_err_count(tx_err_count),
        .rx_err_count(rx_err_count), .evt(evt));

    ////////////////////////////////////////////////////////////////////////
    // 50 ns clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // compare seen against expected
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; read data and error kept in rd and err
    task automatic apb(input logic wr, input logic [CIEF_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check("pready wait", n, 32'd2);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // expected live status bits for given counter values
    function automatic logic [31:0] status_of(input int tx, input int rx);
        logic bo, tw, rw, tp, rp;
        bo = tx >= int'(CIEF_BUS_OFF_LIMIT);
        tw = !bo && tx >= int'(CIEF_WARN_LIMIT);
        rw = rx >= int'(CIEF_WARN_LIMIT);
        tp = !bo && tx >= int'(CIEF_PASSIVE_LIMIT);
        rp = rx >= int'(CIEF_PASSIVE_LIMIT);
        return {18'h0, bo, tp, rp, tw, rw, tw | rw, 8'h00};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state after reset, unmapped access and counter readback
    task automatic t_reset();
        apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
        check("flags after reset", rd, 32'h0);
        apb(1'b0, CIEF_OFS_MASK, 32'h0);
        check("mask after reset", rd, 32'h0);
        check("irq after reset", {31'h0, irq}, 32'h0);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped data", rd, 32'h0);
        i_cief_bus_node.counts(9'h05a, 9'h021);
        apb(1'b0, CIEF_OFS_COUNTS, 32'h0);
        check("counts", rd, {7'h0, 9'h021, 7'h0, 9'h05a});
    endtask

    // every event latches its flag; ones keep, zeros clear one by one
    task automatic t_events();
        logic [31:0] exp;
        exp = 32'h0;
        for (int k = 0; k < 6; k++) begin
            i_cief_bus_node.pulse(k);
            exp[flag_bit[k]] = 1'b1;
            apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
            check("flag set", rd, exp);
        end
        apb(1'b1, CIEF_OFS_FLAGS, 32'hffff_ffff);
        apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
        check("ones written", rd, 32'h0000_00cf);
        for (int k = 0; k < 6; k++) begin
            exp[flag_bit[k]] = 1'b0;
            apb(1'b1, CIEF_OFS_FLAGS, ~(32'h1 << flag_bit[k]));
            apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
            check("flag cleared", rd, exp);
        end
        // wakeup event lands on the very edge of a clearing write
        fork
            apb(1'b1, CIEF_OFS_FLAGS, 32'h0);
            begin
                repeat (2) @(posedge pclk);
                i_cief_bus_node.pulse(4);
            end
        join
        apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
        check("set beats clear", rd, 32'h0000_0040);
    endtask

    // error states across every threshold, summary flag, write protection
    task automatic t_errors();
        int tx [6] = '{96, 128, 256, 0, 0, 95};
        int rx [6] = '{0, 0, 0, 96, 128, 127};
        for (int k = 0; k < 6; k++) begin
            i_cief_bus_node.counts(9'h0, 9'h0);
            apb(1'b1, CIEF_OFS_FLAGS, 32'h0);
            i_cief_bus_node.counts(tx[k][8:0], rx[k][8:0]);
            apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
            check("states", rd, status_of(tx[k], rx[k]) | 32'h20);
            apb(1'b1, CIEF_OFS_FLAGS, 32'h0);
            apb(1'b0, CIEF_OFS_FLAGS, 32'h0);
            check("status write", rd, status_of(tx[k], rx[k]));
        end
        i_cief_bus_node.counts(9'h0, 9'h0);
        apb(1'b1, CIEF_OFS_FLAGS, 32'h0);
    endtask

    // interrupt raised, masked, unmasked and cleared
    task automatic t_irq();
        apb(1'b1, CIEF_OFS_MASK, 32'h0000_0002);
        apb(1'b0, CIEF_OFS_MASK, 32'h0);
        check("mask readback", rd, 32'h0000_0002);
        i_cief_bus_node.pulse(1);
        repeat (3) @(posedge pclk);
        check("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, CIEF_OFS_MASK, 32'h0);
        repeat (3) @(posedge pclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, CIEF_OFS_MASK, 32'h0000_0002);
        repeat (3) @(posedge pclk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        // zero write with the low lane strobe off must not clear
        pstrb <= 4'h0;
        apb(1'b1, CIEF_OFS_FLAGS, 32'h0);
        pstrb <= 4'hf;
        repeat (3) @(posedge pclk);
        check("irq kept unstrobed", {31'h0, irq}, 32'h1);
        apb(1'b1, CIEF_OFS_FLAGS, 32'hffff_fffd);
        repeat (3) @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // cuts a hang short
    initial begin
        #500000;
        mismatches++;
        test_done();
    end

    // reset then scenarios
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_events();
        t_errors();
        t_irq();
        test_done();
    end
endmodule
